/* File: rtl/rmeh_pkg.sv */
/*
 * package of the message error handler: timing counts, carriers, states.
 * assumes a 125 MHz clock and decoder/encoder/backend blocks outside.
 */
// Notes on behaviour
// - illegal command: set flag, still send status
// - broadcast transmit: abort, flag, no status
// - bad data word: abort, flag, no status
// - too few data words abort the transfer; extra words after the count are ignored
// - gap between data words aborts, flags error
// - check sender status sync, address, flags
// - first data sync within 57 us
// - own transmitted words must loop back clean
// - backend cycle timeout aborts the transfer
// - abort or illegal command raises failure pulse
// - abort suppresses status, illegal case excepted
// - bad command word ignored, no interrupt
package rmeh_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned FIRST_DATA_US = 57;
    localparam int unsigned FIRST_DATA_CYC = FIRST_DATA_US * CLK_MHZ;
    localparam int unsigned GAP_CYC = 8;
    localparam int unsigned BACKEND_CYC = 64;
    localparam int unsigned TMR_W = 14;
    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic valid;
        logic sync_ok;
        logic parity_ok;
        logic manch_ok;
        logic [15:0] data;
    } rmeh_word_type;
    typedef struct packed {
        logic [4:0] rt_addr;
        logic tx;
        logic [4:0] subaddr;
        logic [4:0] count;
    } rmeh_cmd_type;
    localparam logic [4:0] BCAST_ADDR = 5'h1F;
    localparam int unsigned SW_MESSAGE_ERROR_FLAG_BIT = 10;
    localparam int unsigned SW_BUSY_BIT = 3;
    typedef enum logic [2:0] {
        ST_IDLE, ST_RX_DATA, ST_RT_WAIT2, ST_RT_STATUS, ST_RT_FIRST, ST_TX_DATA
    } rmeh_state_type;
endpackage : rmeh_pkg

/* File: rtl/rmeh_fifo.sv */
/*
 * synchronous fifo for accepted receive data words.
 * assumes one clock and a sink that may stall.
 */
module rmeh_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 32
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic flush_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic full;
    logic empty;
    assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty = (wr_ptr == rd_ptr);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem[rd_ptr[AW-1:0]];
    always_ff @(posedge clk_i) begin
        if (in_valid_i && !full) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (flush_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (in_valid_i && !full) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (out_ready_i && !empty) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule : rmeh_fifo

/* File: rtl/rmeh_handler.sv */
/*
 * message error handler: screens commands and words, aborts, builds
 * message error flag, status send/suppress, and failure pulse.
 * assumes decoded words arrive as one-cycle pulses on this clock.
 */
module rmeh_handler #(
    parameter int unsigned BACKEND_CYC = rmeh_pkg::BACKEND_CYC,
    parameter int unsigned FIRST_DATA_CYC = rmeh_pkg::FIRST_DATA_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // terminal setup
    input wire logic [4:0] own_addr_i,
    // decoder side
    input wire rmeh_pkg::rmeh_word_type cmd_word_i,
    input wire rmeh_pkg::rmeh_word_type data_word_i,
    input wire rmeh_pkg::rmeh_word_type stat_word_i,
    input wire logic cmd_illegal_i,
    // loopback of own transmission
    input wire logic tx_sent_i,
    input wire logic [15:0] tx_expect_i,
    input wire rmeh_pkg::rmeh_word_type loop_word_i,
    input wire logic tx_done_i,
    // backend
    input wire logic be_req_i,
    input wire logic be_ack_i,
    output logic be_valid_o,
    input wire logic be_ready_i,
    output logic [15:0] be_data_o,
    // status building
    input wire logic sw_built_i,
    output logic message_error_flag_o,
    output logic status_send_o,
    output logic status_suppress_o,
    output logic msg_fail_o,
    output logic abort_o,
    output logic fifo_full_o
);
    rmeh_pkg::rmeh_state_type state;
    rmeh_pkg::rmeh_state_type next_state;
    rmeh_pkg::rmeh_cmd_type cmd;
    rmeh_pkg::rmeh_cmd_type dec;
    logic [5:0] left;
    logic [rmeh_pkg::TMR_W-1:0] tmr;
    logic [15:0] be_tmr;
    logic abort;
    logic illegal_hit;
    logic fifo_ready;
    logic word_ok_d;
    logic loop_ok;

    function automatic logic word_good(input rmeh_pkg::rmeh_word_type w);
        word_good = w.sync_ok && w.parity_ok && w.manch_ok;
    endfunction : word_good

    function automatic logic [5:0] wcount(input logic [4:0] c);
        wcount = (c == 5'h00) ? 6'h20 : {1'b0, c};
    endfunction : wcount

    assign dec = cmd_word_i.data;
    assign word_ok_d = word_good(data_word_i);
    assign loop_ok = word_good(loop_word_i) && (loop_word_i.data == tx_expect_i);
    // ----------------------------------------
    // command screening and abort causes
    // ----------------------------------------
    // a good command for us; bad ones vanish without trace
    logic cmd_seen;
    logic cmd_take;
    // the second command of a peer transfer names the sending terminal
    assign cmd_seen = cmd_word_i.valid && word_good(cmd_word_i);
    assign cmd_take = cmd_word_i.valid && word_good(cmd_word_i)
        && (dec.rt_addr == own_addr_i || dec.rt_addr == rmeh_pkg::BCAST_ADDR);
    assign illegal_hit = cmd_take && (state == rmeh_pkg::ST_IDLE) && cmd_illegal_i;

    always_comb begin
        next_state = state;
        abort = 1'b0;
        case (state)
            rmeh_pkg::ST_IDLE: begin
                if (cmd_take && !cmd_illegal_i) begin
                    if (dec.rt_addr == rmeh_pkg::BCAST_ADDR && dec.tx) begin
                        abort = 1'b1;
                    end else if (dec.tx) begin
                        next_state = rmeh_pkg::ST_TX_DATA;
                    end else begin
                        next_state = rmeh_pkg::ST_RX_DATA;
                    end
                end
            end
            rmeh_pkg::ST_RX_DATA: begin
                if (cmd_seen && (!dec.tx || dec.rt_addr == rmeh_pkg::BCAST_ADDR)) begin
                    abort = 1'b1;
                end else if (cmd_seen) begin
                    next_state = rmeh_pkg::ST_RT_WAIT2;
                end else if (data_word_i.valid && !word_ok_d) begin
                    abort = 1'b1;
                end else if (tmr == '0 || left == 6'h00 && data_word_i.valid) begin
                    abort = 1'b1;
                end else if (data_word_i.valid && left == 6'h01) begin
                    next_state = rmeh_pkg::ST_IDLE;
                end
            end
            rmeh_pkg::ST_RT_WAIT2: begin
                // second command must be a directed transmit
                if (data_word_i.valid || !cmd.tx || cmd.rt_addr == rmeh_pkg::BCAST_ADDR) begin
                    abort = 1'b1;
                end else begin
                    next_state = rmeh_pkg::ST_RT_STATUS;
                end
            end
            rmeh_pkg::ST_RT_STATUS: begin
                if (stat_word_i.valid) begin
                    if (!stat_word_i.sync_ok || stat_word_i.data[15:11] != cmd.rt_addr
                        || stat_word_i.data[rmeh_pkg::SW_MESSAGE_ERROR_FLAG_BIT]
                        || stat_word_i.data[rmeh_pkg::SW_BUSY_BIT]
                        || !word_good(stat_word_i)) begin
                        abort = 1'b1;
                    end else begin
                        next_state = rmeh_pkg::ST_RT_FIRST;
                    end
                end else if (data_word_i.valid) begin
                    abort = 1'b1;
                end
            end
            rmeh_pkg::ST_RT_FIRST: begin
                if (tmr == '0) begin
                    abort = 1'b1;
                end else if (data_word_i.valid) begin
                    next_state = (left == 6'h01) ? rmeh_pkg::ST_IDLE : rmeh_pkg::ST_RX_DATA;
                    abort = !word_ok_d;
                end
            end
            rmeh_pkg::ST_TX_DATA: begin
                if (loop_word_i.valid && !loop_ok) begin
                    abort = 1'b1;
                end else if (tx_done_i) begin
                    next_state = rmeh_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = rmeh_pkg::ST_IDLE;
            end
        endcase
        if (be_tmr == 16'h0001) begin
            abort = 1'b1;
        end
        if (abort) begin
            next_state = rmeh_pkg::ST_IDLE;
        end
    end
    // ----------------------------------------
    // state, command latch, counters
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= rmeh_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmd <= '0;
            left <= '0;
        end else if ((cmd_take && state == rmeh_pkg::ST_IDLE)
            || (cmd_seen && state == rmeh_pkg::ST_RX_DATA)) begin
            cmd <= dec;
            if (state == rmeh_pkg::ST_IDLE) begin
                left <= wcount(dec.count);
            end
        end else if (data_word_i.valid && left != 6'h00) begin
            left <= left - 6'h01;
        end
    end

    // gap timer between words, or first-word window after status
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tmr <= '1;
        end else if (state == rmeh_pkg::ST_RT_STATUS) begin
            tmr <= rmeh_pkg::TMR_W'(FIRST_DATA_CYC);
        end else if (state == rmeh_pkg::ST_IDLE || data_word_i.valid || cmd_take) begin
            // simplification: command-to-data gap uses the word gap budget
            tmr <= rmeh_pkg::TMR_W'(rmeh_pkg::GAP_CYC * 20);
        end else if (tmr != '0) begin
            tmr <= tmr - 1'b1;
        end
    end

    // backend watchdog: 0 idle, counts down while a cycle is open
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            be_tmr <= '0;
        end else if (be_ack_i || abort) begin
            be_tmr <= '0;
        end else if (be_req_i && be_tmr == '0) begin
            be_tmr <= 16'(BACKEND_CYC) + 16'h0001;
        end else if (be_tmr > 16'h0001) begin
            be_tmr <= be_tmr - 16'h0001;
        end
    end
    // ----------------------------------------
    // flag, status decision, failure pulse
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            message_error_flag_o <= 1'b0;
        end else if (abort || illegal_hit) begin
            message_error_flag_o <= 1'b1;
        end else if (sw_built_i) begin
            message_error_flag_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status_send_o <= 1'b0;
            status_suppress_o <= 1'b0;
            msg_fail_o <= 1'b0;
            abort_o <= 1'b0;
        end else begin
            // illegal commands still answer; aborts stay silent
            status_send_o <= illegal_hit;
            status_suppress_o <= abort;
            msg_fail_o <= abort || illegal_hit;
            abort_o <= abort;
        end
    end
    // ----------------------------------------
    // receive data buffer toward backend
    // ----------------------------------------
    // words of an aborted message still in the buffer are flushed rather than delivered
    rmeh_fifo #(
        .WIDTH(16),
        .DEPTH(32)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .flush_i(abort),
        .in_valid_i(data_word_i.valid && word_ok_d
            && (state == rmeh_pkg::ST_RX_DATA || state == rmeh_pkg::ST_RT_FIRST)),
        .in_ready_o(fifo_ready),
        .in_data_i(data_word_i.data),
        .out_valid_o(be_valid_o),
        .out_ready_i(be_ready_i),
        .out_data_o(be_data_o)
    );
    assign fifo_full_o = !fifo_ready;
    logic unused_tx;
    assign unused_tx = tx_sent_i;
endmodule : rmeh_handler

/* File: tb/rmeh_handler_props.sv */
/* checker on the error handler ports.
   assumes it is bound onto rmeh_handler. */
module rmeh_handler_props (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // watched ports
    input wire logic [4:0] own_addr_i,
    input wire rmeh_pkg::rmeh_word_type cmd_word_i,
    input wire logic cmd_illegal_i,
    input wire logic sw_built_i,
    input wire logic message_error_flag_o,
    input wire logic status_send_o,
    input wire logic status_suppress_o,
    input wire logic msg_fail_o,
    input wire logic abort_o,
    input wire logic be_valid_o,
    input wire logic fifo_full_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence good_cmd_s;
        cmd_word_i.valid && cmd_word_i.sync_ok && cmd_word_i.parity_ok && cmd_word_i.manch_ok;
    endsequence
    sequence own_cmd_s;
        good_cmd_s ##0 cmd_word_i.data[15:11] == own_addr_i;
    endsequence
    illegal_status_a: assert property (own_cmd_s ##0 cmd_illegal_i |=>
        status_send_o && msg_fail_o && message_error_flag_o && !status_suppress_o)
        else $error("illegal command not answered");
    bcast_tx_a: assert property (good_cmd_s ##0
        (cmd_word_i.data[15:11] == rmeh_pkg::BCAST_ADDR && cmd_word_i.data[10])
        |=> abort_o && status_suppress_o && message_error_flag_o)
        else $error("broadcast transmit not aborted");
    bad_cmd_quiet_a: assert property (cmd_word_i.valid && !cmd_word_i.parity_ok
        |=> !msg_fail_o && !status_send_o) else $error("bad command word answered");
    abort_fail_a: assert property (abort_o |-> msg_fail_o)
        else $error("abort without failure pulse");
    abort_mute_a: assert property (abort_o |-> status_suppress_o && !status_send_o)
        else $error("status not withheld on abort");
    abort_flag_a: assert property (abort_o |-> message_error_flag_o)
        else $error("abort without error flag");
    flag_hold_a: assert property (message_error_flag_o && !sw_built_i |=>
        message_error_flag_o) else $error("error flag dropped early");
    fail_pulse_a: assert property (msg_fail_o && !cmd_word_i.valid |=> !msg_fail_o)
        else $error("failure pulse too long");
    full_valid_a: assert property (fifo_full_o |-> be_valid_o)
        else $error("full buffer shows no data");
endmodule : rmeh_handler_props

bind rmeh_handler rmeh_handler_props u_props (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .own_addr_i(own_addr_i),
    .cmd_word_i(cmd_word_i),
    .cmd_illegal_i(cmd_illegal_i),
    .sw_built_i(sw_built_i),
    .message_error_flag_o(message_error_flag_o),
    .status_send_o(status_send_o),
    .status_suppress_o(status_suppress_o),
    .msg_fail_o(msg_fail_o),
    .abort_o(abort_o),
    .be_valid_o(be_valid_o),
    .fifo_full_o(fifo_full_o)
);

/* File: tb/rmeh_backend_model.sv */
/* backend stand-in: answers cycles, sinks buffered words.
   assumes one clock; slow_i withholds the answer. */
module rmeh_backend_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // bench control
    input wire logic open_i,
    input wire logic slow_i,
    input wire logic stall_i,
    // toward the handler
    output logic be_req_o,
    output logic be_ack_o,
    output logic be_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // cycle answer
    // ----------------------------------------
    assign be_ready_o = !stall_i;
    // cycle stays open until answered; slow never answers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            be_req_o <= 1'b0;
            be_ack_o <= 1'b0;
        end else begin
            be_ack_o <= be_req_o && !be_ack_o && !slow_i;
            be_req_o <= open_i || (be_req_o && !be_ack_o);
        end
    end
endmodule : rmeh_backend_model

/* File: tb/tb_rmeh_handler.sv */
/* self-checking bench of the message error handler.
   assumes the backend model and the bound checker. */
module tb_rmeh_handler;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // signals and helpers
    // ----------------------------------------
    logic clk_i, rst_b_i, cmd_illegal_i, sw_built_i, open_i, slow_i, stall_i;
    logic be_req_i, be_ack_i, be_ready_i, tx_done_i, tx_sent_i;
    logic [4:0] own_addr_i;
    logic [15:0] tx_expect_i, dat, be_data_o;
    rmeh_pkg::rmeh_word_type cmd_word_i, data_word_i, stat_word_i, loop_word_i;
    logic message_error_flag_o, status_send_o, status_suppress_o, msg_fail_o, abort_o;
    logic be_valid_o, fifo_full_o;
    logic [3:0] ev_exp;
    logic [3:0] evq[$];
    logic [15:0] dq[$];
    int n_mismatch = 0;
    int n_checks = 0;
    localparam logic [3:0] ABT = 4'hB;
    // short counts keep the timeouts quick
    rmeh_handler #(.BACKEND_CYC(4), .FIRST_DATA_CYC(20)) uut (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .own_addr_i(own_addr_i),
        .cmd_word_i(cmd_word_i),
        .data_word_i(data_word_i),
        .stat_word_i(stat_word_i),
        .cmd_illegal_i(cmd_illegal_i),
        .tx_sent_i(tx_sent_i),
        .tx_expect_i(tx_expect_i),
        .loop_word_i(loop_word_i),
        .tx_done_i(tx_done_i),
        .be_req_i(be_req_i),
        .be_ack_i(be_ack_i),
        .be_valid_o(be_valid_o),
        .be_ready_i(be_ready_i),
        .be_data_o(be_data_o),
        .sw_built_i(sw_built_i),
        .message_error_flag_o(message_error_flag_o),
        .status_send_o(status_send_o),
        .status_suppress_o(status_suppress_o),
        .msg_fail_o(msg_fail_o),
        .abort_o(abort_o),
        .fifo_full_o(fifo_full_o)
    );
    rmeh_backend_model model (.clk_i(clk_i), .rst_b_i(rst_b_i), .open_i(open_i),
        .slow_i(slow_i), .stall_i(stall_i), .be_req_o(be_req_i), .be_ack_o(be_ack_i),
        .be_ready_o(be_ready_i));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    task automatic check(string name, logic [15:0] got, logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic stop_test();
        $display("mismatches %0d checks %0d", n_mismatch, n_checks);
        if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    task automatic put(int sel, logic [2:0] ok, logic [15:0] d, logic ill = 1'b0);
        rmeh_pkg::rmeh_word_type w;
        w = {1'b1, ok, d};
        @(posedge clk_i);
        cmd_illegal_i <= ill;
        case (sel)
            0: cmd_word_i <= w;
            1: data_word_i <= w;
            2: stat_word_i <= w;
            default: loop_word_i <= w;
        endcase
        @(posedge clk_i);
        cmd_illegal_i <= 1'b0;
        {cmd_word_i, data_word_i, stat_word_i, loop_word_i} <= '0;
    endtask : put
    task automatic wait_ev();
        for (int i = 0; i < 400 && evq.size() > 0; i++) @(posedge clk_i);
    endtask : wait_ev
    task automatic settle(logic flag);
        wait_ev();
        check("events left", 16'(evq.size()), 16'h0);
        repeat (2) @(posedge clk_i);
        check("flag", {15'h0, message_error_flag_o}, {15'h0, flag});
        sw_built_i <= 1'b1;
        @(posedge clk_i);
        sw_built_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check("flag cleared", {15'h0, message_error_flag_o}, 16'h0);
    endtask : settle
    function automatic logic [15:0] cw(logic [4:0] a, logic tx, logic [4:0] n);
        return {a, tx, 5'h02, n};
    endfunction : cw
    // result watcher: oldest note against each pulse or drained word
    always @(posedge clk_i) begin
        if (rst_b_i && (abort_o || msg_fail_o)) begin
            ev_exp = evq.size() > 0 ? evq.pop_front() : 4'hX;
            check("events", {12'h0, abort_o, status_send_o, status_suppress_o, msg_fail_o},
                16'(ev_exp));
        end
        if (rst_b_i && be_valid_o && be_ready_i)
            check("drained word", be_data_o,
                dq.size() > 0 ? dq.pop_front() : 16'hXXXX);
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        stop_test();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        {cmd_word_i, data_word_i, stat_word_i, loop_word_i} = '0;
        {cmd_illegal_i, sw_built_i, open_i, slow_i, stall_i, tx_done_i, tx_sent_i} = '0;
        tx_expect_i = 16'h0;
        void'($urandom(32'hDF282EE2));
        own_addr_i = 5'($urandom_range(29, 0));
        rst_b_i = 1'b0;
        repeat (8) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        check("flag at reset", {15'h0, message_error_flag_o}, 16'h0);
        put(0, 3'b101, cw(own_addr_i, 1'b0, 5'h02));
        settle(1'b0);
        evq.push_back(4'h5);
        put(0, 3'h7, cw(own_addr_i, 1'b0, 5'h02), 1'b1);
        settle(1'b1);
        evq.push_back(ABT);
        put(0, 3'h7, cw(rmeh_pkg::BCAST_ADDR, 1'b1, 5'h02));
        settle(1'b1);
        // manchester, parity, sync fault, then a silent gap
        for (int k = 0; k < 4; k++) begin
            dat = 16'($urandom);
            dq.push_back(dat);
            put(0, 3'h7, cw(own_addr_i, 1'b0, 5'h03));
            put(1, 3'h7, dat);
            evq.push_back(ABT);
            if (k < 3) put(1, 3'h7 ^ (3'h1 << k), dat);
            settle(1'b1);
        end
        slow_i <= 1'b1;
        put(0, 3'h7, cw(own_addr_i, 1'b0, 5'h03));
        evq.push_back(ABT);
        open_i <= 1'b1;
        @(posedge clk_i);
        open_i <= 1'b0;
        wait_ev();
        slow_i <= 1'b0;
        settle(1'b1);
        // peer transfer: late first data, then a busy sender
        // a broadcast second command ends the last pass early
        for (int k = 0; k < 3; k++) begin
            put(0, 3'h7, cw(own_addr_i, 1'b0, 5'h02));
            put(0, 3'h7, cw((k == 2) ? rmeh_pkg::BCAST_ADDR : (own_addr_i ^ 5'h01),
                1'b1, 5'h02));
            evq.push_back(ABT);
            put(2, 3'h7, {own_addr_i ^ 5'h01, 11'(k << 3)});
            settle(1'b1);
        end
        // clean own transmission ends quietly on the done pulse
        put(0, 3'h7, cw(own_addr_i, 1'b1, 5'h01));
        tx_expect_i <= 16'h5A5A;
        put(3, 3'h7, 16'h5A5A);
        tx_done_i <= 1'b1;
        @(posedge clk_i);
        tx_done_i <= 1'b0;
        settle(1'b0);
        evq.push_back(ABT);
        put(0, 3'h7, cw(own_addr_i, 1'b1, 5'h01));
        tx_expect_i <= 16'hA5A5;
        put(3, 3'h7, 16'h5A5A);
        settle(1'b1);
        // count 0 means 32 words: fill the stalled buffer, then drain
        stall_i <= 1'b1;
        put(0, 3'h7, cw(own_addr_i, 1'b0, 5'h00));
        for (int k = 0; k < 32; k++) begin
            dat = 16'($urandom);
            dq.push_back(dat);
            put(1, 3'h7, dat);
        end
        @(posedge clk_i);
        check("fifo full", {15'h0, fifo_full_o}, 16'h1);
        stall_i <= 1'b0;
        for (int i = 0; i < 100 && dq.size() > 0; i++) @(posedge clk_i);
        check("words left", 16'(dq.size()), 16'h0);
        stop_test();
    end
endmodule : tb_rmeh_handler
